// [rdbus_master.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// - line moves four long words, one address
// - refused burst finishes with three singles
// - all bus signals on rising clock
// - single reads ignore cache inhibit
// - noncachable or non-allocating fills and fetches read singly
// - first clock drives address, attributes, start
// - after first clock release bus, negate start
// - no acknowledge means wait and resample
// - acknowledge edge captures data, ends cycle
// - line reads for block move, line fill
// - slave steps index bits within block
// - slave puts data with each acknowledge
// - burst inhibit turns rest into singles
// - inhibited line stays one locked transfer
// - burst inhibit sampled on first beat only
// - cache inhibit captured, line still completed
// - cache inhibit ignored after first beat
// - slave ignores the two byte bits
// - fetch at half line, stall till needed
// - master steps index bits for singles
module rdbus_master
  import rdbus_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  rdbus_if.master bus,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [WIDTH_W-1:0] req_width,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic cache_enable,
  input wire logic noncachable,
  input wire logic implicit_noncache,
  input wire logic no_allocate,
  output logic req_ready,
  output logic [ADDR_W-1:0] rd_data,
  output logic rd_valid,
  output logic [1:0] rd_index,
  output logic line_cache_inhibit,
  output logic line_done,
  output logic exec_release,
  output logic bus_locked
);

  typedef enum {M_IDLE, M_ADDR, M_DATA} mstate_t;

  // The slave shares this clock, so its strobes are taken straight off the bus.
  // Extra flops would hide a one-cycle acknowledge and delay every capture.
  logic ack_seen, bi_seen, ci_seen;

  mstate_t st_reg, st_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [WIDTH_W-1:0] width_reg, width_next;
  logic line_reg, line_next;
  logic inhib_reg, inhib_next;
  logic [1:0] beat_reg, beat_next;
  logic fetch_reg, fetch_next;
  // Long word of the half line that holds the fetched instruction.
  logic need_reg, need_next;
  logic [ADDR_W-1:0] data_reg, data_next;
  logic valid_reg, valid_next;
  logic [1:0] idx_reg, idx_next;
  logic tci_reg, tci_next;
  logic done_reg, done_next;
  logic rel_reg, rel_next;
  logic line_req;

  // rising-edge sampling
  // Decoded strobes are taken by the state registers at the next rising edge.
  assign ack_seen = !bus.transfer_ack_n;
  assign bi_seen = !bus.burst_inhibit_n;
  assign ci_seen = !bus.cache_inhibit_in_n;

  assign line_req = (req_kind == REQ_MOVE) ||
                    ((req_kind == REQ_FILL || req_kind == REQ_IFETCH) &&
                     cache_enable && !noncachable && !implicit_noncache && !no_allocate);

  // New requests only when no transfer, locked line included, is open.
  // no gap for arbitration
  assign req_ready = (st_reg == M_IDLE);
  assign bus_locked = (st_reg != M_IDLE);

  // Next-state logic of the read master.
  always_comb begin
    st_next = st_reg;
    addr_next = addr_reg;
    width_next = width_reg;
    line_next = line_reg;
    inhib_next = inhib_reg;
    beat_next = beat_reg;
    fetch_next = fetch_reg;
    need_next = need_reg;
    data_next = data_reg;
    valid_next = 1'b0;
    idx_next = idx_reg;
    tci_next = tci_reg;
    done_next = 1'b0;
    rel_next = 1'b0;
    case (st_reg)
      M_IDLE: begin
        if (req_valid) begin
          line_next = line_req;
          inhib_next = 1'b0;
          beat_next = 2'h0;
          tci_next = 1'b0;
          fetch_next = (req_kind == REQ_IFETCH);
          // The aligned address loses this bit, so it is kept apart.
          need_next = req_addr[HALF_BIT];
          width_next = line_req ? XW_LINE : req_width;
          addr_next = req_addr;
          if (req_kind == REQ_IFETCH) begin
            addr_next = req_addr & HALF_MASK;
          end
          st_next = M_ADDR;
        end
      end
      M_ADDR: begin
        st_next = M_DATA;
      end
      M_DATA: begin
        if (ack_seen) begin
          data_next = bus.ad;
          valid_next = 1'b1;
          idx_next = beat_reg;
          if (line_reg && beat_reg == 2'h0) begin
            tci_next = ci_seen;
            inhib_next = bi_seen;
          end
          if (fetch_reg && beat_reg == {1'b0, need_reg}) begin
            rel_next = 1'b1;
          end
          if (!line_reg || beat_reg == LAST_BEAT) begin
            done_next = line_reg;
            st_next = M_IDLE;
          end else begin
            beat_next = beat_reg + 2'h1;
            if (inhib_next) begin
              addr_next[LW_HI:LW_LO] = addr_reg[LW_HI:LW_LO] + 2'h1;
              width_next = XW_LONG;
              st_next = M_ADDR;
            end
          end
        end
      end
      default: begin
        st_next = M_IDLE;
      end
    endcase
  end

  // Registers of the read master.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg <= M_IDLE;
      addr_reg <= '0;
      width_reg <= XW_LONG;
      line_reg <= 1'b0;
      inhib_reg <= 1'b0;
      beat_reg <= 2'h0;
      fetch_reg <= 1'b0;
      need_reg <= 1'b0;
      data_reg <= '0;
      valid_reg <= 1'b0;
      idx_reg <= 2'h0;
      tci_reg <= 1'b0;
      done_reg <= 1'b0;
      rel_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      addr_reg <= addr_next;
      width_reg <= width_next;
      line_reg <= line_next;
      inhib_reg <= inhib_next;
      beat_reg <= beat_next;
      fetch_reg <= fetch_next;
      need_reg <= need_next;
      data_reg <= data_next;
      valid_reg <= valid_next;
      idx_reg <= idx_next;
      tci_reg <= tci_next;
      done_reg <= done_next;
      rel_reg <= rel_next;
    end
  end

  assign bus.transfer_start_n = !(st_reg == M_ADDR);
  assign bus.ad_oe_m = (st_reg == M_ADDR);
  assign bus.ad_out_m = addr_reg;
  assign bus.xfer_width = width_reg;

  // User-side results, all from flops.
  assign rd_data = data_reg;
  assign rd_valid = valid_reg;
  assign rd_index = idx_reg;
  assign line_cache_inhibit = tci_reg;
  assign line_done = done_reg;
  assign exec_release = rel_reg;

endmodule
`default_nettype wire

// [rdbus_pkg.sv]
package rdbus_pkg;

  // Address and data width of the shared multiplexed bus.
  localparam int ADDR_W = 32;
  // Transfer width code width.
  localparam int WIDTH_W = 2;

  // Transfer width codes driven during the address phase.
  localparam logic [1:0] XW_LONG = 2'h0;
  localparam logic [1:0] XW_BYTE = 2'h1;
  localparam logic [1:0] XW_WORD = 2'h2;
  localparam logic [1:0] XW_LINE = 2'h3;

  // Long words in one 16-byte line and the last beat index.
  localparam logic [1:0] LAST_BEAT = 2'h3;
  // Bit positions of the long-word index inside an address.
  localparam int LW_LO = 2;
  localparam int LW_HI = 3;
  // Bit that selects the upper long word of a half line.
  localparam int HALF_BIT = 2;
  // Low address bits cleared for a half-line aligned fetch.
  localparam logic [ADDR_W-1:0] HALF_MASK = 32'hfffffff8;

  // Request kinds offered by the user side of the master.
  localparam logic [1:0] REQ_SINGLE = 2'h0;
  localparam logic [1:0] REQ_MOVE = 2'h1;
  localparam logic [1:0] REQ_FILL = 2'h2;
  localparam logic [1:0] REQ_IFETCH = 2'h3;

  // Wait count loaded at reset; a wait_states setting equal to it means no wait.
  localparam logic [3:0] WAIT_RESET = 4'h0;

endpackage

// [rdbus_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Shared multiplexed bus between the read master and a slave controller.
interface rdbus_if;
  import rdbus_pkg::*;
  // Master drive of the shared address/data lines and its enable.
  logic [ADDR_W-1:0] ad_out_m;
  logic ad_oe_m;
  // Slave drive of the shared lines and its enable.
  logic [ADDR_W-1:0] ad_out_s;
  logic ad_oe_s;
  // Resolved level of the shared lines.
  logic [ADDR_W-1:0] ad;
  // Transfer attributes and handshake strobes, all active low where named _n.
  logic [WIDTH_W-1:0] xfer_width;
  logic transfer_start_n;
  logic transfer_ack_n;
  logic burst_inhibit_n;
  logic cache_inhibit_in_n;

  // The slave drive wins; an idle bus reads as zero.
  assign ad = ad_oe_s ? ad_out_s : (ad_oe_m ? ad_out_m : '0);

  modport master (
    output ad_out_m, ad_oe_m, xfer_width, transfer_start_n,
    input ad, transfer_ack_n, burst_inhibit_n, cache_inhibit_in_n
  );
  modport slave (
    output ad_out_s, ad_oe_s, transfer_ack_n, burst_inhibit_n, cache_inhibit_in_n,
    input ad, xfer_width, transfer_start_n
  );
endinterface
`default_nettype wire

// [rdbus_slave.sv]
`timescale 1ns/1ps
`default_nettype none
// Slave-side controller: answers reads from a user-side memory port.
module rdbus_slave
  import rdbus_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  rdbus_if.slave bus,
  input wire logic [3:0] wait_states,
  input wire logic no_burst,
  input wire logic no_cache,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [ADDR_W-1:0] mem_data
);

  typedef enum {S_IDLE, S_WAIT, S_ACK} sstate_t;

  sstate_t st_reg, st_next;
  // Latched address with its long-word index stepped per beat.
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic line_reg, line_next;
  logic first_reg, first_next;
  logic [1:0] beat_reg, beat_next;
  logic [3:0] wcnt_reg, wcnt_next;

  // Memory sees the word address; the two byte bits are not used.
  // ignore byte bits
  assign mem_addr = {addr_reg[ADDR_W-1:LW_LO], 2'h0};

  // Next-state logic of the slave handshake.
  always_comb begin
    st_next = st_reg;
    addr_next = addr_reg;
    line_next = line_reg;
    first_next = first_reg;
    beat_next = beat_reg;
    wcnt_next = wcnt_reg;
    case (st_reg)
      S_IDLE: begin
        // A start strobe latches the address phase.
        if (!bus.transfer_start_n) begin
          addr_next = bus.ad;
          line_next = (bus.xfer_width == XW_LINE);
          first_next = 1'b1;
          beat_next = 2'h0;
          wcnt_next = wait_states;
          st_next = (wait_states == WAIT_RESET) ? S_ACK : S_WAIT;
        end
      end
      S_WAIT: begin
        wcnt_next = wcnt_reg - 4'h1;
        if (wcnt_reg == 4'h1) begin
          st_next = S_ACK;
        end
      end
      S_ACK: begin
        first_next = 1'b0;
        // A single read, or a refused burst, ends after one beat.
        if (!line_reg || (first_reg && no_burst) || beat_reg == LAST_BEAT) begin
          st_next = S_IDLE;
        end else begin
          addr_next[LW_HI:LW_LO] = addr_reg[LW_HI:LW_LO] + 2'h1;
          beat_next = beat_reg + 2'h1;
          wcnt_next = wait_states;
          st_next = (wait_states == WAIT_RESET) ? S_ACK : S_WAIT;
        end
      end
      default: begin
        st_next = S_IDLE;
      end
    endcase
  end

  // Registers of the slave handshake.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg <= S_IDLE;
      addr_reg <= '0;
      line_reg <= 1'b0;
      first_reg <= 1'b0;
      beat_reg <= 2'h0;
      wcnt_reg <= WAIT_RESET;
    end else begin
      st_reg <= st_next;
      addr_reg <= addr_next;
      line_reg <= line_next;
      first_reg <= first_next;
      beat_reg <= beat_next;
      wcnt_reg <= wcnt_next;
    end
  end

  assign bus.ad_oe_s = (st_reg == S_ACK);
  assign bus.ad_out_s = mem_data;
  assign bus.transfer_ack_n = !(st_reg == S_ACK);
  assign bus.burst_inhibit_n = !(st_reg == S_ACK && first_reg && line_reg && no_burst);
  assign bus.cache_inhibit_in_n = !(st_reg == S_ACK && first_reg && no_cache);

endmodule
`default_nettype wire

// [rdbus_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the shared bus between the two ends from the outside.
module rdbus_chk
  import rdbus_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] ad_out_m,
  input wire logic ad_oe_m,
  input wire logic ad_oe_s,
  input wire logic [WIDTH_W-1:0] xfer_width,
  input wire logic transfer_start_n,
  input wire logic transfer_ack_n,
  input wire logic burst_inhibit_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Index and width seen at the latest address phase.
  logic [1:0] idx_reg;
  logic [1:0] idx_next;
  logic [WIDTH_W-1:0] wid_reg;
  logic [WIDTH_W-1:0] wid_next;
  // High from an address phase until its first acknowledge.
  logic busy_reg;
  logic busy_next;
  // A new address phase replaces the stored values.
  always_comb begin
    idx_next = idx_reg;
    wid_next = wid_reg;
    busy_next = busy_reg;
    if (!transfer_start_n) begin
      idx_next = ad_out_m[3:2];
      wid_next = xfer_width;
    end
    // An acknowledge closes the wait; a new address phase opens one.
    if (!transfer_ack_n) begin
      busy_next = 1'b0;
    end
    if (!transfer_start_n) begin
      busy_next = 1'b1;
    end
  end
  // Registers the stored values.
  always_ff @(posedge ref_clk) begin
    idx_reg <= nrst ? idx_next : 2'h0;
    wid_reg <= nrst ? wid_next : XW_LONG;
    busy_reg <= nrst ? busy_next : 1'b0;
  end
  a_start_one_clk: assert property (!transfer_start_n |=> transfer_start_n)
    else $error("start strobe held longer than one clock");
  a_addr_with_start: assert property (!transfer_start_n |-> ad_oe_m && !ad_oe_s)
    else $error("address not driven by master with start");
  a_bus_release: assert property (ad_oe_m |=> !ad_oe_m)
    else $error("master kept driving the shared bus");
  a_one_open: assert property (busy_reg && transfer_ack_n |=> transfer_start_n)
    else $error("new address phase before the last one ended");
  a_ack_bounded: assert property (!transfer_start_n |-> ##[1:16] !transfer_ack_n)
    else $error("no acknowledge within the wait limit");
  a_ack_data: assert property (!transfer_ack_n |-> ad_oe_s)
    else $error("acknowledge without data on the bus");
  a_inhibit_long: assert property (wid_reg == XW_LINE && !burst_inhibit_n && !transfer_ack_n
    |-> ##[1:24] (!transfer_start_n && xfer_width == XW_LONG))
    else $error("inhibited line not continued by a long read");
  a_step_index: assert property (wid_reg == XW_LINE && !burst_inhibit_n && !transfer_ack_n
    |-> ##[1:24] (!transfer_start_n && ad_out_m[3:2] == idx_reg + 2'h1))
    else $error("follow-on read did not step the index");
  a_burst_stay: assert property (wid_reg == XW_LINE && burst_inhibit_n && !transfer_ack_n
    |=> transfer_start_n)
    else $error("address phase right after a burst beat");
  cover property (!transfer_start_n ##1 !transfer_ack_n);
  cover property (!transfer_start_n && xfer_width == XW_LINE);
  cover property (wid_reg == XW_LINE && !burst_inhibit_n && !transfer_ack_n);
endmodule
`default_nettype wire

// [processor_bus_read_master_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Drives the user sides of both ends and checks the master results.
module processor_bus_read_master_tb_top;
  import rdbus_pkg::*;
  logic ref_clk, nrst, req_valid, cache_enable, noncachable, implicit_noncache, no_allocate;
  logic [1:0] req_kind, req_width, rd_index;
  logic [31:0] req_addr, rd_data, mem_addr, mem_data;
  logic req_ready, rd_valid, line_cache_inhibit, line_done, exec_release, bus_locked;
  logic [3:0] wait_states;
  logic no_burst, no_cache;
  // Kind of the next random request, kept off the design's inputs.
  logic [1:0] kind_r;
  int n_errors, checks_done, i;
  rdbus_if bus_if();
  // Memory contents are a fixed function of the long-word address.
  function automatic logic [31:0] wd(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  assign mem_data = wd(mem_addr);
  rdbus_master u_rdbus_master (.ref_clk(ref_clk), .nrst(nrst), .bus(bus_if), .req_valid(req_valid),
    .req_kind(req_kind), .req_width(req_width), .req_addr(req_addr), .cache_enable(cache_enable),
    .noncachable(noncachable), .implicit_noncache(implicit_noncache), .no_allocate(no_allocate),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_index(rd_index),
    .line_cache_inhibit(line_cache_inhibit), .line_done(line_done), .exec_release(exec_release),
    .bus_locked(bus_locked));
  rdbus_slave u_rdbus_slave (.ref_clk(ref_clk), .nrst(nrst), .bus(bus_if),
    .wait_states(wait_states), .no_burst(no_burst), .no_cache(no_cache),
    .mem_addr(mem_addr), .mem_data(mem_data));
  rdbus_chk u_rdbus_chk (.ref_clk(ref_clk), .nrst(nrst), .ad_out_m(bus_if.ad_out_m),
    .ad_oe_m(bus_if.ad_oe_m), .ad_oe_s(bus_if.ad_oe_s), .xfer_width(bus_if.xfer_width),
    .transfer_start_n(bus_if.transfer_start_n), .transfer_ack_n(bus_if.transfer_ack_n),
    .burst_inhibit_n(bus_if.burst_inhibit_n));
  // Compares one value and reports a mismatch.
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Issues one request and checks every beat against the model.
  task automatic do_req(input logic [1:0] kind, input logic [31:0] addr, input logic [1:0] w,
    input logic [3:0] cond, input logic [3:0] ws, input logic nb, input logic nci);
    logic single;
    logic [31:0] st;
    int n, k, t;
    // Block moves are always lines; fills and fetches fall back to singles.
    single = (kind == REQ_SINGLE) ||
      (kind != REQ_MOVE && (!cond[3] || (cond[2:0] != 3'h0)));
    st = (kind == REQ_IFETCH) ? (addr & HALF_MASK) : addr;
    n = single ? 1 : 4;
    k = 0;
    t = 0;
    while (req_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    #5;
    {cache_enable, noncachable, implicit_noncache, no_allocate} = cond;
    {req_kind, req_addr, req_width, wait_states, no_burst, no_cache} = {kind, addr, w, ws, nb, nci};
    req_valid = 1'b1;
    @(posedge ref_clk);
    #5;
    req_valid = 1'b0;
    while (k < n && t < 500) begin
      @(negedge ref_clk);
      t++;
      if (rd_valid === 1'b1) begin
        chk("rd_data", wd({st[31:4], st[3:2] + k[1:0], 2'h0}), rd_data);
        chk("rd_index", k, rd_index);
        chk("line_done", !single && k == 3, line_done);
        if (kind == REQ_IFETCH) chk("exec_release", k == addr[2], exec_release);
        if (k < n - 1) chk("bus_locked", 1, bus_locked);
        k++;
      end
    end
    chk("beats", n, k);
    chk("line_cache_inhibit", !single && nci, line_cache_inhibit);
    chk("bus_locked_end", 0, bus_locked);
    chk("req_ready", 1, req_ready);
  endtask
  // Clock source.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Cuts a hung run short.
  initial begin
    #1000000;
    n_errors++;
    summarize();
  end
  // Main sequence: directed cases first, then random requests.
  initial begin
    {nrst, req_valid, req_kind, req_width, req_addr} = '0;
    {cache_enable, noncachable, implicit_noncache, no_allocate} = 4'h8;
    {wait_states, no_burst, no_cache} = '0;
    n_errors = 0;
    checks_done = 0;
    i = $urandom(35653);
    repeat (2) @(posedge ref_clk);
    #5;
    nrst = 1'b1;
    for (i = 0; i < 3; i++) begin
      do_req(REQ_SINGLE, 32'h00001003 + i * 4, i[1:0], 4'h8, 4'h0, 1'b1, 1'b1);
      do_req(REQ_FILL, 32'h00002000 + i * 4, XW_LONG, i ? (4'h8 | (4'h1 << (3 - i))) : 4'h0,
        4'h1, 1'b0, 1'b1);
    end
    for (i = 0; i < 4; i++) begin
      do_req(REQ_MOVE, 32'h00003000 + i * 4, XW_LINE, 4'h8, {2'h0, i[1:0]}, 1'b0, i[0]);
      do_req(REQ_FILL, 32'h00004001 + i * 4, XW_LINE, 4'h8, i[3:0], 1'b1, i[1]);
      do_req(REQ_IFETCH, 32'h1000000c - i * 4, XW_LINE, 4'h8, 4'h3, i[1], 1'b0);
    end
    for (i = 0; i < 20; i++) begin
      kind_r = 2'($urandom % 4);
      do_req(kind_r, $urandom, 2'($urandom % 3), (kind_r != REQ_IFETCH && $urandom % 3 == 0)
        ? 4'($urandom) : 4'h8, 4'(2 + $urandom % 4), 1'($urandom), 1'($urandom));
    end
    summarize();
  end
endmodule
`default_nettype wire
